// [bench/mfc_core_model.sv]
module mfc_core_model
	import mfc_pkg::*;
(
	// clock and abort from the unit
	input wire logic clk_i,
	input wire mfc_pkg::mfc_abort_s abort_i,
	// access and walk results to the unit
	output mfc_pkg::mfc_access_s acc_o,
	output mfc_pkg::mfc_walk_s walk_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		acc_o = '0;
		walk_o = '0;
	end
	// one access for one cycle, then the lines show a different pattern
	task automatic issue(input mfc_access_s a, input mfc_walk_s w,
		input logic exec, output mfc_abort_s ab, output logic taken);
		mfc_access_s r;
		r = ~a;
		r.valid = 1'h0;
		@(posedge clk_i);
		acc_o <= a;
		walk_o <= w;
		@(posedge clk_i);
		acc_o <= r;
		walk_o <= ~w;
		#1 ab = abort_i;
		// a fetch abort counts only if the instruction executes
		taken = ab.abort && (ab.data || exec);
	endtask
endmodule // mfc_core_model

// [bench/tb_top.sv]
module tb_top;
	import mfc_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, ex = 0, ce = 1;
	logic [7:0] pa = '0;
	logic [31:0] pwd = '0, prd, fsr_e = '0, far_e = '0, pid_e = '0;
	logic rdy, serr, tk;
	logic [31:0] LF = 32'h08004A40, V = 32'h01234560;
	mfc_access_s acc;
	mfc_walk_s walk;
	mfc_abort_s ab;
	int n_mismatch = 0, num_checks = 0;
	always #2.5 clk = ~clk;
	mfc_fault_check i_dut(.CLK_SYS_I(clk), .RST_I(rst), .CE_I(ce),
		.PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa),
		.PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(serr),
		.ACC_I(acc), .WALK_I(walk), .ABORT_O(ab));
	mfc_core_model i_core(.clk_i(clk), .abort_i(ab), .acc_o(acc),
		.walk_o(walk));
	task chk(input string nm, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1;
		pen <= 0;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1;
		do @(posedge clk); while (rdy !== 1'h1);
		r = prd;
		e = serr;
		psel <= 0;
		pen <= 0;
	endtask
	task rc(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'h0, a, '0, r, e);
		chk("rdata", x, r);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'h1, a, d, r, e);
	endtask
	function logic [31:0] sd(input logic [3:0] d, input logic [1:0] p);
		return {20'h0, p, 1'h0, d, 5'h12};
	endfunction
	function logic [31:0] pd(input logic [3:0] d);
		return {23'h0, d, 5'h11};
	endfunction
	// c: data,word,user,write  pg: l2 type,ap  x: abort,code,domain
	task run(input logic [3:0] c, input logic [31:0] va, l1,
		input logic [3:0] pg, er, input logic [8:0] x);
		mfc_abort_s o;
		i_core.issue({1'h1, c[3], c[2], c[0], c[1], va},
			{l1, pg, er[3:1], LF, er[0]}, ex, o, tk);
		chk("abort", x[8], o.abort);
		if (x[8]) begin
			chk("cause", x[7:0], {o.code, o.domain});
			chk("adata", c[3], o.data);
		end
		if (x[8] && c[3]) begin
			fsr_e = {24'h000000, x[3:0], x[7:4]};
			far_e = (x[7:4] == 4'h4 || x[7:4] == 4'h6) ? LF : va;
			if (far_e[31:25] == 7'h0)
				far_e[31:25] = pid_e[31:25];
		end
		rc(8'h0C, fsr_e);
		rc(8'h10, far_e);
	endtask
	task s_regs;
		logic [31:0] r;
		logic e;
		for (int i = 0; i < 5; i++)
			rc(8'(i * 4), '0);
		apb(1'h0, 8'h14, '0, r, e);
		chk("pslverr", 1'h1, e);
		chk("rdata", '0, r);
		wr(8'h00, 32'hA5C30F96);
		rc(8'h00, 32'hA5C30F96);
		wr(8'h04, 32'hFFFFFFFF);
		rc(8'h04, 32'h00000303);
		wr(8'h0C, 32'hFFFFFFFF);
		rc(8'h0C, '0);
	endtask
	task s_align;
		wr(8'h04, 32'h2);
		wr(8'h00, 32'h360);
		run(4'hE, 32'h1002, sd(3, 1), 0, 4'h8, 9'h110);
		run(4'hA, 32'h1003, '0, 0, 0, 9'h0);
		run(4'h6, 32'h1001, '0, 0, 0, 9'h0);
	endtask
	task s_walk;
		wr(8'h04, 32'h3);
		run(4'hE, V, sd(3, 3), 0, 4'h8, 9'h1C0);
		run(4'hE, V, pd(3), 0, 4'h4, 9'h1E3);
		run(4'hE, V, 32'h63, 0, 0, 9'h150);
		run(4'hE, V, pd(3), 4'h3, 0, 9'h173);
		run(4'hE, V, sd(1, 3), 0, 0, 9'h191);
		run(4'hE, V, sd(2, 3), 0, 0, 9'h192);
		run(4'hE, V, pd(1), 4'hB, 0, 9'h1B1);
		run(4'hE, V, sd(3, 1), 0, 4'h1, 9'h1D3);
		run(4'hF, V, pd(3), 4'hA, 0, 9'h1F3);
		run(4'hE, V, sd(3, 2), 0, 0, 9'h0);
		run(4'hE, V, sd(4, 1), 0, 0, 9'h0);
		run(4'hE, V, sd(4, 1), 0, 4'h2, 9'h144);
		run(4'hE, V, pd(4), 4'h9, 4'h2, 9'h164);
		run(4'hE, V, sd(4, 1), 0, 4'h1, 9'h184);
		run(4'hE, V, pd(4), 4'h9, 4'h1, 9'h1A4);
		wr(8'h04, 32'h103);
		run(4'hC, V, sd(3, 0), 0, 0, 9'h0);
		run(4'hD, V, sd(3, 0), 0, 0, 9'h1D3);
	endtask
	task s_pref;
		ex = 0;
		run(4'h6, V, sd(3, 3), 0, 4'h8, 9'h1C0);
		chk("taken", 1'h0, tk);
		ex = 1;
		run(4'h6, V, sd(3, 3), 0, 4'h8, 9'h1C0);
		chk("taken", 1'h1, tk);
	endtask
	task s_pid;
		pid_e = 32'h04000000;
		wr(8'h08, pid_e);
		run(4'hE, 32'h1001, sd(4, 1), 0, 0, 9'h110);
	endtask
	// a faulting access while the clock enable is low must leave no trace
	task s_ce;
		mfc_abort_s o;
		ce <= 0;
		i_core.issue({5'h1C, 32'h00001002}, '0, ex, o, tk);
		@(posedge clk);
		ce <= 1;
		chk("abort", 1'h0, o.abort);
		rc(8'h0C, fsr_e);
		rc(8'h10, far_e);
	endtask
	// reset in mid-run clears the fault and control registers
	task s_rst;
		@(posedge clk);
		rst <= 1;
		@(posedge clk);
		rst <= 0;
		rc(8'h0C, '0);
		rc(8'h10, '0);
		rc(8'h08, '0);
		rc(8'h04, '0);
		rc(8'h00, '0);
	endtask
	task results;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		s_regs;
		s_align;
		s_walk;
		s_pref;
		s_pid;
		s_ce;
		s_rst;
		results;
	end
	// about 24 accesses of some 8 cycles each; far more than needed
	initial begin
		#20000;
		n_mismatch++;
		results;
	end
endmodule // tb_top

// [rtl/mfc_fault_check.sv]
// Contract
// - data abort stores 4-bit cause code and 4-bit domain in status register
// - data abort latches the offending virtual address into address register
// - several faults at once: only highest priority one is recorded
// - alignment fault: code 0001, domain invalid, address valid
// - walk bus error: level one 1100 no domain, level two 1110 with domain
// - descriptor low bits equal: translation fault, section 0101, page 0111
// - domain no access or reserved: fault 1001 section, 1011 page
// - section permissions use access bits and system bit; 1101 or 1111
// - linefetch bus error 0100/0110, address is linefetch start
// - other bus error 1000/1010, lowest priority
// - prefetch abort leaves status and address registers unchanged
// - nonzero process id: address register holds modified address
// - 32-bit domain register holds sixteen 2-bit domain fields
// - domain value 00 or 10 faults every access
// - domain value 01 checks the descriptor access bits
// - domain value 11 bypasses access bits, no permission fault
// - control bit 1: misaligned word data access faults, mmu on or off
// - no alignment fault on instruction fetch or byte access
// - misaligned access aborts at once, no domain or permission checks
// - level one domain field selects the domain, checked on return
// - access bits decode with system and rom protect bits
//
// Decided for this implementation: the register offsets and the APB register port.
`include "mfc_params.svh"

module mfc_fault_check (
	// clock, reset, enable
	input wire logic CLK_SYS_I,
	input wire logic RST_I,
	input wire logic CE_I,
	// apb slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// access and walk results from the core side
	input wire mfc_pkg::mfc_access_s ACC_I,
	input wire mfc_pkg::mfc_walk_s WALK_I,
	// abort to the core
	output mfc_pkg::mfc_abort_s ABORT_O
);
	import mfc_pkg::*;

	logic [31:0] dacr;
	logic [31:0] ctrl;
	logic [31:0] pid;
	logic [7:0] fault_status_register;
	logic [31:0] far_q;
	mfc_abort_s abort_q;

	// domain field lookup
	function automatic logic [1:0] dom_field(input logic [31:0] d,
		input logic [3:0] n);
		dom_field = d[{n, 1'h0} +: 2];
	endfunction

	// access permission decode
	function automatic logic ap_ok(input logic [1:0] ap, input logic s,
		input logic r, input logic user, input logic wr);
		unique case (ap)
			2'h0: ap_ok = !wr && ((s && !r && !user) || (!s && r));
			2'h1: ap_ok = !user;
			2'h2: ap_ok = !user || !wr;
			2'h3: ap_ok = 1'h1;
		endcase
	endfunction

	// process-modified address
	function automatic logic [31:0] mod_va(input logic [31:0] va,
		input logic [31:0] p);
		mod_va = (va[31:25] == 7'h00) ? {p[31:25], va[24:0]} : va;
	endfunction

	// register bus decode
	wire setup = PSEL_I && !PENABLE_I;
	wire wr_en = PSEL_I && PENABLE_I && PWRITE_I;
	wire hit_dacr = PADDR_I == `MFC_OFS_DACR;
	wire hit_ctrl = PADDR_I == `MFC_OFS_CTRL;
	wire hit_pid = PADDR_I == `MFC_OFS_PID;
	wire hit_fsr = PADDR_I == `MFC_OFS_FSR;
	wire hit_far = PADDR_I == `MFC_OFS_FAR;
	wire mapped = hit_dacr || hit_ctrl || hit_pid || hit_fsr || hit_far;
	wire [31:0] next_rdata =
		hit_dacr ? dacr :
		hit_ctrl ? ctrl :
		hit_pid ? pid :
		hit_fsr ? {24'h000000, fault_status_register} :
		hit_far ? far_q : 32'h00000000;

	assign PREADY_O = 1'b1;

	// control fields
	wire mmu_on = ctrl[`MFC_CTRL_MMU];
	wire align_en = ctrl[`MFC_CTRL_ALIGN];
	wire sys_p = ctrl[`MFC_CTRL_SYS];
	wire rom_p = ctrl[`MFC_CTRL_ROM];

	// descriptor decode
	wire [31:0] l1 = WALK_I.l1_desc;
	wire is_page = mmu_on && (l1[1:0] == 2'h1);
	wire l1_bad = l1[1] == l1[0];
	wire l2_bad = WALK_I.l2_type[1] == WALK_I.l2_type[0];
	wire [3:0] dom_sel = l1[`MFC_L1_DOM_LSB +: 4];
	wire [1:0] dom_bits = dom_field(dacr, dom_sel);
	wire dom_client = dom_bits == 2'h1;
	wire [1:0] ap = is_page ? WALK_I.page_ap : l1[`MFC_L1_AP_LSB +: 2];
	wire ap_pass = ap_ok(ap, sys_p, rom_p, ACC_I.user, ACC_I.write);

	// fault sources
	wire misalign = ACC_I.data && ACC_I.word && align_en &&
		(ACC_I.vaddr[1:0] != 2'h0);
	wire f_l1e = mmu_on && WALK_I.l1_err;
	wire f_l2e = is_page && WALK_I.l2_err;
	wire f_tsec = mmu_on && l1_bad;
	wire f_tpg = is_page && l2_bad;
	wire f_dom = mmu_on && !dom_bits[0];
	wire f_perm = mmu_on && dom_client && !ap_pass;
	wire f_lf = WALK_I.lf_err;
	wire f_oth = WALK_I.other_err;
	wire f_walk = f_l1e || f_l2e || f_tsec || f_tpg;
	wire f_mmu = f_walk || f_dom || f_perm;
	wire any_fault = misalign || f_mmu || f_lf || f_oth;
	wire lf_wins = !misalign && !f_mmu && f_lf;
	wire take = ACC_I.valid && any_fault;
	wire take_data = take && ACC_I.data;

	// priority encode, alignment first and other bus error last
	wire [3:0] next_code =
		misalign ? `MFC_FS_ALIGN :
		f_l1e ? `MFC_FS_BUS_L1 :
		f_l2e ? `MFC_FS_BUS_L2 :
		f_tsec ? `MFC_FS_TR_SEC :
		f_tpg ? `MFC_FS_TR_PG :
		f_dom ? (is_page ? `MFC_FS_DOM_PG : `MFC_FS_DOM_SEC) :
		f_perm ? (is_page ? `MFC_FS_PERM_PG : `MFC_FS_PERM_SEC) :
		f_lf ? (is_page ? `MFC_FS_LF_PG : `MFC_FS_LF_SEC) :
		(is_page ? `MFC_FS_BUS_PG : `MFC_FS_BUS_SEC);
	wire dom_valid = !(misalign || f_l1e || f_tsec);
	wire [3:0] next_dom = dom_valid ? dom_sel : `MFC_DOM_INVALID;
	wire [31:0] next_far = lf_wins ? mod_va(WALK_I.lf_addr, pid) :
		mod_va(ACC_I.vaddr, pid);

	mfc_abort_s next_abort;
	assign next_abort = '{abort: take, data: ACC_I.data,
		code: next_code, domain: next_dom};

	// apb read path and error answer
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			PRDATA_O <= 32'h00000000;
			PSLVERR_O <= 1'b0;
		end else if (CE_I && setup) begin
			PRDATA_O <= next_rdata;
			PSLVERR_O <= !mapped;
		end
	end

	// software registers
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			dacr <= `MFC_RST_DACR;
			ctrl <= `MFC_RST_CTRL;
			pid <= `MFC_RST_PID;
		end else if (CE_I && wr_en) begin
			if (hit_dacr)
				dacr <= PWDATA_I;
			if (hit_ctrl)
				ctrl <= PWDATA_I & `MFC_CTRL_MASK;
			if (hit_pid)
				pid <= PWDATA_I & `MFC_PID_MASK;
		end
	end

	// fault capture, data aborts only
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			fault_status_register <= 8'h00;
			far_q <= 32'h00000000;
		end else if (CE_I && take_data) begin
			fault_status_register <= {next_dom, next_code};
			far_q <= next_far;
		end
	end

	// abort to the core, one cycle after the access
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I)
			abort_q <= '0;
		else if (CE_I)
			abort_q <= next_abort;
	end

	assign ABORT_O = abort_q;

	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (RST_I);

	a_fsr_capture: assert property (CE_I && take_data |=>
		fault_status_register == {$past(next_dom), $past(next_code)})
		else $error("fault status not captured");

	a_far_capture: assert property (CE_I && take_data |=>
		far_q == $past(next_far))
		else $error("fault address not captured");

	a_prefetch_keeps: assert property (CE_I && take && !ACC_I.data
		|=> $stable(fault_status_register) && $stable(far_q))
		else $error("prefetch abort changed fault registers");

	a_align_first: assert property (CE_I && ACC_I.valid &&
		misalign && ACC_I.data |=> ABORT_O.abort &&
		fault_status_register == {`MFC_DOM_INVALID, `MFC_FS_ALIGN})
		else $error("alignment fault not reported first");

	a_no_align_fetch: assert property (!(ACC_I.data &&
		ACC_I.word) |-> !misalign)
		else $error("alignment fault on fetch or byte");

	a_manager_bypass: assert property (dom_bits == 2'h3
		|-> !f_perm && !f_dom)
		else $error("manager domain faulted");

	a_no_access_dom: assert property (mmu_on && !misalign &&
		!f_walk && !dom_bits[0] |-> next_code[3] && next_code[0] &&
		!next_code[2])
		else $error("no access domain without domain fault");

	a_trans_code: assert property (mmu_on && !misalign && !f_l1e
		&& l1_bad |-> next_code == `MFC_FS_TR_SEC &&
		next_dom == `MFC_DOM_INVALID)
		else $error("section translation fault miscoded");

	a_abort_pulse: assert property (CE_I ##1 CE_I &&
		$past(ACC_I.valid && !any_fault) |-> !ABORT_O.abort)
		else $error("abort without fault");

	a_dacr_write: assert property (CE_I && wr_en && hit_dacr
		|=> dacr == $past(PWDATA_I))
		else $error("domain register write lost");

	a_pid_far: assert property (CE_I && take_data && lf_wins &&
		pid == 32'h00000000 |=> far_q == $past(WALK_I.lf_addr))
		else $error("linefetch start not captured");

	c_align: cover property (CE_I && ACC_I.valid && misalign);
	c_perm_pg: cover property (CE_I && take_data &&
		next_code == `MFC_FS_PERM_PG);
	c_linefetch: cover property (CE_I && take_data && lf_wins);
	c_prefetch: cover property (CE_I && take && !ACC_I.data);
	c_other_bus: cover property (CE_I && take_data && !misalign &&
		!f_mmu && !f_lf);

	a_abort_data: assert property (CE_I && take |=> ABORT_O.abort &&
		ABORT_O.data == $past(ACC_I.data))
		else $error("abort kind not passed on");

	a_align_code: assert property (CE_I && take && misalign |=>
		ABORT_O.code == `MFC_FS_ALIGN &&
		ABORT_O.domain == `MFC_DOM_INVALID)
		else $error("alignment fault miscoded");

	a_l1_bus_code: assert property (CE_I && take && !misalign &&
		f_l1e |=> ABORT_O.code == `MFC_FS_BUS_L1 &&
		ABORT_O.domain == `MFC_DOM_INVALID)
		else $error("level one bus error miscoded");

	a_l2_bus_code: assert property (CE_I && take && !misalign &&
		!f_l1e && f_l2e |=> ABORT_O.code == `MFC_FS_BUS_L2 &&
		ABORT_O.domain == $past(dom_sel))
		else $error("level two bus error miscoded");

	a_page_trans: assert property (CE_I && take && !misalign &&
		!f_l1e && !f_l2e && f_tpg |=> ABORT_O.code == `MFC_FS_TR_PG &&
		ABORT_O.domain == $past(dom_sel))
		else $error("page translation fault miscoded");

	a_dom_page: assert property (CE_I && ACC_I.valid && !misalign &&
		!f_walk && is_page && f_dom |=>
		ABORT_O.code == `MFC_FS_DOM_PG)
		else $error("page domain fault miscoded");

	a_perm_section: assert property (CE_I && ACC_I.valid && mmu_on &&
		!is_page && !misalign && !f_walk && dom_client && !ap_pass
		|=> ABORT_O.code == `MFC_FS_PERM_SEC)
		else $error("section permission fault miscoded");

	a_lf_code: assert property (CE_I && take && lf_wins |=>
		ABORT_O.code == ($past(is_page) ? `MFC_FS_LF_PG :
		`MFC_FS_LF_SEC))
		else $error("linefetch bus error miscoded");

	a_other_last: assert property (CE_I && take && !misalign &&
		!f_mmu && !f_lf |=> ABORT_O.code == ($past(is_page) ?
		`MFC_FS_BUS_PG : `MFC_FS_BUS_SEC))
		else $error("other bus error miscoded");

	a_far_plain: assert property (CE_I && take_data && !lf_wins &&
		pid == 32'h00000000 |=> far_q == $past(ACC_I.vaddr))
		else $error("fault address differs from access");

	a_far_modified: assert property (CE_I && take_data &&
		!lf_wins && ACC_I.vaddr[31:25] == 7'h00 |=>
		far_q == {$past(pid[31:25]), $past(ACC_I.vaddr[24:0])})
		else $error("process modified address not captured");

	a_dom_low: assert property (dom_sel == 4'h0
		|-> dom_bits == dacr[1:0])
		else $error("domain zero field misselected");

	a_dom_high: assert property (dom_sel == 4'hF
		|-> dom_bits == dacr[31:30])
		else $error("domain fifteen field misselected");

	a_null_dom: assert property (mmu_on && dom_bits == 2'h0
		|-> f_dom)
		else $error("no access domain did not fault");

	a_resv_dom: assert property (mmu_on && dom_bits == 2'h2
		|-> f_dom)
		else $error("reserved domain did not fault");

	a_client_check: assert property (mmu_on && dom_client &&
		!ap_pass |-> f_perm)
		else $error("client access bits not applied");

	a_align_mmu_off: assert property (CE_I && ACC_I.valid &&
		!mmu_on && misalign |=> ABORT_O.abort &&
		ABORT_O.code == `MFC_FS_ALIGN)
		else $error("alignment fault lost with mmu off");

	a_align_enable: assert property (!align_en
		|-> !misalign)
		else $error("alignment fault while checking is off");

	a_align_nodom: assert property (misalign
		|-> next_code == `MFC_FS_ALIGN &&
		next_dom == `MFC_DOM_INVALID)
		else $error("misaligned access went on to later checks");

	a_ap_super: assert property (ap == 2'h1
		|-> ap_pass == !ACC_I.user)
		else $error("supervisor only access bits misdecoded");

	a_ap_user_ro: assert property (ap == 2'h2
		|-> ap_pass == !(ACC_I.user && ACC_I.write))
		else $error("user read only access bits misdecoded");

	a_ap_full: assert property (ap == 2'h3
		|-> ap_pass)
		else $error("full access bits refused an access");

	a_ap_resv: assert property (ap == 2'h0 && sys_p && rom_p
		|-> !ap_pass)
		else $error("reserved protect setting allowed access");

	a_regs_readonly: assert property (CE_I && wr_en &&
		(hit_fsr || hit_far) && !take_data |=>
		$stable(fault_status_register) && $stable(far_q))
		else $error("software write changed fault registers");

	a_ce_freeze: assert property (!CE_I |=> $stable(fault_status_register) &&
		$stable(far_q) && $stable(dacr) && $stable(ctrl) &&
		$stable(pid) && $stable(ABORT_O))
		else $error("state moved while clock enable low");

	a_slverr_unmapped: assert property (CE_I && setup && !mapped
		|=> PSLVERR_O && PRDATA_O == 32'h00000000)
		else $error("unmapped address not refused");

	a_dacr_read: assert property (CE_I && setup && hit_dacr
		|=> PRDATA_O == $past(dacr))
		else $error("domain register read wrong");

endmodule // mfc_fault_check

// [rtl/mfc_params.svh]
`ifndef MFC_PARAMS_SVH
`define MFC_PARAMS_SVH

// register byte offsets
`define MFC_OFS_DACR 8'h00
`define MFC_OFS_CTRL 8'h04
`define MFC_OFS_PID 8'h08
`define MFC_OFS_FSR 8'h0C
`define MFC_OFS_FAR 8'h10

// reset values
`define MFC_RST_DACR 32'h00000000
`define MFC_RST_CTRL 32'h00000000
`define MFC_RST_PID 32'h00000000

// control register fields
`define MFC_CTRL_MMU 0
`define MFC_CTRL_ALIGN 1
`define MFC_CTRL_SYS 8
`define MFC_CTRL_ROM 9
`define MFC_CTRL_MASK 32'h00000303
`define MFC_PID_MASK 32'hFE000000

// descriptor fields
`define MFC_L1_DOM_LSB 5
`define MFC_L1_AP_LSB 10

// fault cause codes
`define MFC_FS_ALIGN 4'h1
`define MFC_FS_BUS_L1 4'hC
`define MFC_FS_BUS_L2 4'hE
`define MFC_FS_TR_SEC 4'h5
`define MFC_FS_TR_PG 4'h7
`define MFC_FS_DOM_SEC 4'h9
`define MFC_FS_DOM_PG 4'hB
`define MFC_FS_PERM_SEC 4'hD
`define MFC_FS_PERM_PG 4'hF
`define MFC_FS_LF_SEC 4'h4
`define MFC_FS_LF_PG 4'h6
`define MFC_FS_BUS_SEC 4'h8
`define MFC_FS_BUS_PG 4'hA
`define MFC_DOM_INVALID 4'h0

`endif

// [rtl/mfc_pkg.sv]
package mfc_pkg;

	// one access presented by the core
	typedef struct packed {
		logic valid;
		logic data;
		logic word;
		logic write;
		logic user;
		logic [31:0] vaddr;
	} mfc_access_s;

	// walker and bus results that belong to the access
	typedef struct packed {
		logic [31:0] l1_desc;
		logic [1:0] l2_type;
		logic [1:0] page_ap;
		logic l1_err;
		logic l2_err;
		logic lf_err;
		logic [31:0] lf_addr;
		logic other_err;
	} mfc_walk_s;

	typedef struct packed {
		logic abort;
		logic data;
		logic [3:0] code;
		logic [3:0] domain;
	} mfc_abort_s;

endpackage
